// ==== rtl/lan_wake_filter_and_source_log.sv ====
// Wake-on-LAN detection and wake-cause log of an Ethernet MAC receive path.
// Assumes a classic Wishbone master, a receive datapath on clock_in that
// marks frame start and end and gives its verdicts with the end byte,
// and a power manager that reports suspend, entry to suspend and resume.
//
// Notes on behaviour
// - Magic enable wakes; resume may clear it.
// - Broadcast enable wakes; resume may clear it.
// - Log ignores events entering suspend or waking.
// - One packet sets every matching cause bit.
// - Cause bits stay until software clears them; EEE off also clears the low-power bits.
// - Eight pin cause bits, one per pin.
// - Separate IPv6 and IPv4 SYN cause bits.
// - Five frame cause bits, each its own.
// - Transmit low-power exit cause, gated and forced.
// - Receive low-power exit cause, gated and forced.
// - Five-bit index of matching pattern filter.
// - Thirty-two filters spanning 128 bytes each.
// - Filter used only while enable bit set.
// - Address type selects unicast, multicast or all.
// - Eight-bit offset marks first checked byte.
// - CRC-16 over masked bytes equals expected value.
// - Mask bit j includes byte offset plus j.
// - Filter zero reloads image on lite reset.
// - Address entry: valid, type, 48-bit address.
// - Checksum bypass leaves only frame check.
// - Forward selects pass or drop ARP, NS.
`timescale 1ns/10ps
`include "wake_filter_regs.svh"

module lan_wake_filter_and_source_log
  import wake_filter_pkg::*;
#(
  parameter int N_FILT = `WF_NUM_FILTERS,
  parameter int N_ADDR = `WF_NUM_ADDR
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [11:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_sof_in,
  input wire logic rx_eof_in,
  input wire logic rx_good_in,
  input wire logic rx_csum_ok_in,
  input wire logic rx_filter_pass_in,
  input wire logic rx_magic_in,
  input wire logic rx_v4_syn_in,
  input wire logic rx_v6_syn_in,
  input wire logic rx_arp_in,
  input wire logic rx_ns_in,
  input wire logic tx_lpi_exit_in,
  input wire logic rx_lpi_exit_in,
  input wire logic [7:0] pin_wake_in,
  input wire logic suspend_state_in,
  input wire logic entering_suspend_in,
  input wire logic resume_done_in,
  input wire logic lite_reset_in,
  input wire logic image_valid_in,
  input wire logic [31:0] image_cfg_in,
  input wire logic [127:0] image_mask_in,
  output logic wake_request_out,
  output logic frame_discard_out
);

  // ----------------------------------------------------------------
  // Elaboration checks and helpers
  // ----------------------------------------------------------------
  if (N_FILT < 1 || N_FILT > `WF_NUM_FILTERS || N_ADDR < 1 || N_ADDR > `WF_NUM_ADDR) begin : g_chk
    $error("filter or address entry count outside the register map");
  end

  function automatic crc_t crc16_byte(input crc_t c, input logic [7:0] d);
    crc_t r;
    r = c;
    for (int k = 7; k >= 0; k--) begin
      r = (r[15] ^ d[k]) ? ({r[14:0], 1'b0} ^ `WF_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc16_byte

  function automatic logic in_block(input logic [11:0] a, input logic [11:0] b, input int n);
    logic [11:0] d;
    d = a - b;
    return (a >= b) && (int'(d[11:2]) < n);
  endfunction : in_block

  function automatic logic [6:0] word_idx(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] d;
    d = a - b;
    return d[8:2];
  endfunction : word_idx

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] cfg_ff [N_FILT];
  logic [31:0] mask_ff [N_FILT * `WF_MASK_WORDS];
  logic [31:0] addr_ff [N_ADDR * 2];
  crc_t crc_ff [N_FILT];
  crc_t nxt_crc [N_FILT];
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic aw_cfg_ff, aw_mask_ff, aw_addr_ff, nxt_aw_cfg, nxt_aw_mask, nxt_aw_addr;
  logic [6:0] aw_idx_ff, nxt_aw_idx;
  logic [31:0] aw_dat_ff, nxt_aw_dat;
  logic load_pend_ff, nxt_load_pend;
  logic [31:0] img_cfg;
  logic [127:0] img_mask;
  logic [31:0] ctrl_ff, nxt_ctrl, aux_ff, nxt_aux, offl_ff, nxt_offl, log_ff, nxt_log;
  wake_state_t state_ff, nxt_state;
  logic [8:0] cnt_ff, nxt_cnt, pos, ofs, rel;
  logic [47:0] dest_ff, nxt_dest;
  logic [7:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
  logic discard_ff, nxt_discard;
  logic req, wr, hit_cfg, hit_mask, hit_addr, frame_end, good, syn_ok;
  logic mc, bcast, da_hit, pat_hit, armed;
  logic [31:0] wm, a_al, log_clr, ev, log_set;
  logic [6:0] ci, mi, ai;
  logic [4:0] pat_idx;
  logic [1:0] at;
  crc_t c;

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rdata_ff;
  assign wake_request_out = (state_ff == ST_WAKING);
  assign frame_discard_out = discard_ff;

  // ----------------------------------------------------------------
  // Wishbone slave: answers every request one cycle later
  // ----------------------------------------------------------------
  always_comb begin
    req = wb_cyc_in && wb_stb_in && !ack_ff;
    wr = req && wb_we_in;
    wm = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    a_al = {20'h0_0000, wb_adr_in[11:2], 2'b00};
    hit_cfg = in_block(a_al[11:0], `WF_CFG_BASE, N_FILT);
    hit_mask = in_block(a_al[11:0], `WF_MASK_BASE, N_FILT * `WF_MASK_WORDS);
    hit_addr = in_block(a_al[11:0], `WF_ADDR_BASE, N_ADDR * 2);
    ci = hit_cfg ? word_idx(a_al[11:0], `WF_CFG_BASE) : 7'h00;
    mi = hit_mask ? word_idx(a_al[11:0], `WF_MASK_BASE) : 7'h00;
    ai = hit_addr ? word_idx(a_al[11:0], `WF_ADDR_BASE) : 7'h00;
    nxt_ack = req;
    nxt_rdata = rdata_ff;
    if (req && !wb_we_in) begin
      nxt_rdata = 32'h0000_0000;
      case (a_al[11:0])
        `WF_CTRL_ADR: nxt_rdata = ctrl_ff;
        `WF_LOG_ADR: nxt_rdata = log_ff;
        `WF_AUX_ADR: nxt_rdata = aux_ff;
        `WF_OFFL_ADR: nxt_rdata = offl_ff;
        default: begin
          if (hit_cfg) nxt_rdata = cfg_ff[ci[4:0]];
          else if (hit_mask) nxt_rdata = mask_ff[mi];
          else if (hit_addr) nxt_rdata = addr_ff[ai];
        end
      endcase
    end
    nxt_aw_cfg = wr && hit_cfg;
    nxt_aw_mask = wr && hit_mask;
    nxt_aw_addr = wr && hit_addr;
    nxt_aw_idx = hit_cfg ? ci : (hit_mask ? mi : ai);
    if (hit_cfg) begin
      nxt_aw_dat = ((cfg_ff[ci[4:0]] & ~wm) | (wb_dat_in & wm)) & `WF_CFG_WMASK;
    end else if (hit_mask) begin
      nxt_aw_dat = (mask_ff[mi] & ~wm) | (wb_dat_in & wm);
    end else if (!ai[0]) begin
      nxt_aw_dat = ((addr_ff[ai] & ~wm) | (wb_dat_in & wm)) & `WF_ADDR_HI_WMASK;
    end else begin
      nxt_aw_dat = (addr_ff[ai] & ~wm) | (wb_dat_in & wm);
    end
    // Filter zero image: restored after reset and on every lite reset
    nxt_load_pend = lite_reset_in;
    img_cfg = image_valid_in ? (image_cfg_in & `WF_CFG_WMASK) : 32'h0000_0000;
    img_mask = image_valid_in ? image_mask_in : 128'h0;
  end

  // Writes land one edge after the request, the edge that samples ack
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      aw_cfg_ff <= 1'b0;
      aw_mask_ff <= 1'b0;
      aw_addr_ff <= 1'b0;
      aw_idx_ff <= 7'h00;
      aw_dat_ff <= 32'h0000_0000;
      load_pend_ff <= 1'b1;
      for (int i = 0; i < N_FILT; i++) cfg_ff[i] <= 32'h0000_0000;
      for (int i = 0; i < N_FILT * `WF_MASK_WORDS; i++) mask_ff[i] <= 32'h0000_0000;
      for (int i = 0; i < N_ADDR * 2; i++) addr_ff[i] <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      aw_cfg_ff <= nxt_aw_cfg;
      aw_mask_ff <= nxt_aw_mask;
      aw_addr_ff <= nxt_aw_addr;
      aw_idx_ff <= nxt_aw_idx;
      aw_dat_ff <= nxt_aw_dat;
      load_pend_ff <= nxt_load_pend;
      if (aw_cfg_ff) cfg_ff[aw_idx_ff[4:0]] <= aw_dat_ff;
      if (aw_mask_ff) mask_ff[aw_idx_ff] <= aw_dat_ff;
      if (aw_addr_ff) addr_ff[aw_idx_ff] <= aw_dat_ff;
      if (load_pend_ff) begin
        cfg_ff[0] <= img_cfg;
        for (int w = 0; w < `WF_MASK_WORDS; w++) mask_ff[w] <= img_mask[w * 32 +: 32];
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame path: byte position, destination, per-filter CRC
  // ----------------------------------------------------------------
  always_comb begin
    nxt_crc = crc_ff;
    frame_end = rx_valid_in && rx_eof_in;
    pos = rx_sof_in ? 9'h000 : cnt_ff;
    nxt_cnt = cnt_ff;
    nxt_dest = dest_ff;
    if (rx_valid_in) begin
      nxt_cnt = (pos == `WF_CNT_MAX) ? pos : pos + 9'h001;
      if (pos < 9'h006) nxt_dest = {(rx_sof_in ? 40'h0 : dest_ff[39:0]), rx_data_in};
    end
    mc = dest_ff[40];
    bcast = &dest_ff;
    pat_hit = 1'b0;
    pat_idx = 5'h00;
    ofs = 9'h000;
    rel = 9'h000;
    at = 2'b00;
    c = `WF_CRC_INIT;
    // Lowest numbered matching filter is reported
    for (int i = N_FILT - 1; i >= 0; i--) begin
      ofs = {1'b0, cfg_ff[i][`WF_CFG_OFS_LO +: 8]};
      rel = pos - ofs;
      c = rx_sof_in ? `WF_CRC_INIT : crc_ff[i];
      if (rx_valid_in && pos >= ofs && rel < `WF_PATTERN_SPAN &&
          mask_ff[i * `WF_MASK_WORDS + int'(rel[6:5])][rel[4:0]]) begin
        c = crc16_byte(c, rx_data_in);
      end
      if (rx_valid_in) nxt_crc[i] = c;
      at = cfg_ff[i][`WF_CFG_AT_LO +: 2];
      if (cfg_ff[i][`WF_CFG_EN] && (at[0] || (at[1] == mc)) &&
          c == cfg_ff[i][`WF_CFG_CRC_MSB:0]) begin
        pat_hit = 1'b1;
        pat_idx = 5'(i);
      end
    end
    da_hit = 1'b0;
    // A cleared valid bit keeps a half-written entry out of matching
    for (int e = 0; e < N_ADDR; e++) begin
      if (addr_ff[2 * e][`WF_AV] && !addr_ff[2 * e][`WF_AT] &&
          {addr_ff[2 * e][`WF_AHI_MSB:0], addr_ff[2 * e + 1]} == dest_ff) da_hit = 1'b1;
    end
    nxt_discard = frame_end && ((rx_arp_in && !offl_ff[`WF_FARP]) ||
                                (rx_ns_in && !offl_ff[`WF_FNS]));
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_ff <= 9'h000;
      dest_ff <= 48'h0;
      discard_ff <= 1'b0;
      pin_meta_ff <= 8'h00;
      pin_sync_ff <= 8'h00;
      pin_prev_ff <= 8'h00;
      for (int i = 0; i < N_FILT; i++) crc_ff[i] <= `WF_CRC_INIT;
    end else begin
      cnt_ff <= nxt_cnt;
      dest_ff <= nxt_dest;
      discard_ff <= nxt_discard;
      pin_meta_ff <= pin_wake_in;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
      crc_ff <= nxt_crc;
    end
  end

  // ----------------------------------------------------------------
  // Wake causes, wake state and control registers
  // ----------------------------------------------------------------
  always_comb begin
    good = frame_end && rx_good_in;
    syn_ok = good && (offl_ff[`WF_BYPASS] || rx_csum_ok_in);
    ev = 32'h0000_0000;
    ev[`WF_PIN_LO +: 8] = pin_sync_ff & ~pin_prev_ff & aux_ff[`WF_PIN_LO +: 8];
    ev[`WF_LOG_V6] = syn_ok && rx_v6_syn_in && offl_ff[`WF_V6_EN];
    ev[`WF_LOG_V4] = syn_ok && rx_v4_syn_in && offl_ff[`WF_V4_EN];
    ev[`WF_LOG_TXLP] = tx_lpi_exit_in && ctrl_ff[`WF_TXLP_EN] && aux_ff[`WF_EEE];
    ev[`WF_LOG_RXLP] = rx_lpi_exit_in && ctrl_ff[`WF_RXLP_EN] && aux_ff[`WF_EEE];
    ev[`WF_LOG_RFE] = good && rx_filter_pass_in && ctrl_ff[`WF_RFE_EN];
    ev[`WF_LOG_DA] = good && da_hit && ctrl_ff[`WF_DA_EN];
    ev[`WF_LOG_MP] = good && rx_magic_in && ctrl_ff[`WF_MP_EN];
    ev[`WF_LOG_BC] = good && bcast && ctrl_ff[`WF_BC_EN];
    ev[`WF_LOG_WU] = good && pat_hit && ctrl_ff[`WF_WU_EN];
    ev[`WF_IDX_MSB:0] = ev[`WF_LOG_WU] ? pat_idx : 5'h00;
    armed = (state_ff == ST_ARMED) && suspend_state_in && !entering_suspend_in;
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: if (suspend_state_in && !entering_suspend_in) nxt_state = ST_ARMED;
      ST_ARMED: begin
        if (!suspend_state_in) nxt_state = ST_RUN;
        else if (armed && |ev[31:`WF_LOG_CAUSE_LO]) nxt_state = ST_WAKING;
      end
      ST_WAKING: if (resume_done_in) nxt_state = ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
    // Every cause of the waking event lands together
    log_set = (armed && |ev[31:`WF_LOG_CAUSE_LO]) ? ev : 32'h0000_0000;
    log_clr = (wr && a_al[11:0] == `WF_LOG_ADR) ? (wb_dat_in & wm) : 32'h0000_0000;
    nxt_log = (log_ff & ~log_clr) | log_set;
    if (log_set[`WF_LOG_WU]) nxt_log[`WF_IDX_MSB:0] = log_set[`WF_IDX_MSB:0];
    if (!aux_ff[`WF_EEE]) begin
      nxt_log[`WF_LOG_TXLP] = 1'b0;
      nxt_log[`WF_LOG_RXLP] = 1'b0;
    end
    nxt_ctrl = ctrl_ff;
    nxt_aux = aux_ff;
    nxt_offl = offl_ff;
    if (wr && a_al[11:0] == `WF_CTRL_ADR) nxt_ctrl = ((ctrl_ff & ~wm) | (wb_dat_in & wm)) & `WF_CTRL_MASK;
    if (wr && a_al[11:0] == `WF_AUX_ADR) nxt_aux = ((aux_ff & ~wm) | (wb_dat_in & wm)) & `WF_AUX_MASK;
    if (wr && a_al[11:0] == `WF_OFFL_ADR) nxt_offl = ((offl_ff & ~wm) | (wb_dat_in & wm)) & `WF_OFFL_MASK;
    if (resume_done_in && aux_ff[`WF_RCLR]) begin
      nxt_ctrl = 32'h0000_0000;
      nxt_offl[`WF_V4_EN] = 1'b0;
      nxt_offl[`WF_V6_EN] = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= ST_RUN;
      log_ff <= 32'h0000_0000;
      ctrl_ff <= 32'h0000_0000;
      aux_ff <= 32'h0000_0000;
      offl_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      log_ff <= nxt_log;
      ctrl_ff <= nxt_ctrl;
      aux_ff <= nxt_aux;
      offl_ff <= nxt_offl;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_log_sticky_mp: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (log_ff[`WF_LOG_MP] && !log_clr[`WF_LOG_MP]) |=> log_ff[`WF_LOG_MP])
    else $error("magic cause bit dropped without a clear");
  chk_waking_frozen: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (state_ff == ST_WAKING && log_clr == 32'h0 && aux_ff[`WF_EEE]) |=> $stable(log_ff))
    else $error("log changed after waking began");
  chk_wake_latch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (armed && ev[`WF_LOG_MP]) |=> (wake_request_out && log_ff[`WF_LOG_MP]))
    else $error("wake request or cause not latched next cycle");
  chk_multi_cause: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (armed && ev[`WF_LOG_MP] && ev[`WF_LOG_BC]) |=> (log_ff[`WF_LOG_MP] && log_ff[`WF_LOG_BC]))
    else $error("only one cause logged for a multi-cause packet");
  chk_resume_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (resume_done_in && aux_ff[`WF_RCLR]) |=> (!ctrl_ff[`WF_MP_EN] && !ctrl_ff[`WF_BC_EN]))
    else $error("enables survived resume with clear set");
  chk_bcast_gated: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (!ctrl_ff[`WF_BC_EN] && log_clr == 32'h0) |=> (log_ff[`WF_LOG_BC] == $past(log_ff[`WF_LOG_BC])))
    else $error("broadcast cause set while disabled");
  chk_eee_forced: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !aux_ff[`WF_EEE] |=> (!log_ff[`WF_LOG_TXLP] && !log_ff[`WF_LOG_RXLP]))
    else $error("low-power cause set while energy mode off");
  chk_syn_gate: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    ev[`WF_LOG_V4] |-> (rx_good_in && (offl_ff[`WF_BYPASS] || rx_csum_ok_in)))
    else $error("SYN cause without integrity checks");
  chk_arp_discard: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (frame_end && rx_arp_in && !rx_ns_in) |=> (frame_discard_out == !$past(offl_ff[`WF_FARP])))
    else $error("ARP forward select not honoured");
  chk_image_load: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (lite_reset_in && !aw_cfg_ff) |=> ##1 (cfg_ff[0] == $past(img_cfg)))
    else $error("filter zero not restored after lite reset");
  chk_bus_ack: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    req |=> (wb_ack_out ##1 !wb_ack_out))
    else $error("ack not one cycle after request");

endmodule : lan_wake_filter_and_source_log

// ==== rtl/wake_filter_regs.svh ====
// Register map, field positions and fixed counts of the wake filter.
// Assumes inclusion by bare name from the design files.
`ifndef WAKE_FILTER_REGS_SVH
`define WAKE_FILTER_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define WF_CTRL_ADR 12'h140
`define WF_LOG_ADR 12'h144
`define WF_AUX_ADR 12'h148
`define WF_CFG_BASE 12'h150
`define WF_MASK_BASE 12'h200
`define WF_ADDR_BASE 12'h400
`define WF_OFFL_ADR 12'h600

// ----------------------------------------------------------------
// Counts, writable masks and CRC
// ----------------------------------------------------------------
`define WF_NUM_FILTERS 32
`define WF_NUM_ADDR 33
`define WF_MASK_WORDS 4
`define WF_PATTERN_SPAN 9'h080
`define WF_CNT_MAX 9'h1ff
`define WF_CTRL_MASK 32'h0000_540f
`define WF_AUX_MASK 32'h0ff0_0003
`define WF_OFFL_MASK 32'h8000_0603
`define WF_CFG_WMASK 32'h83ff_ffff
`define WF_ADDR_HI_WMASK 32'hc000_ffff
`define WF_CRC_POLY 16'h8005
`define WF_CRC_INIT 16'hffff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WF_BC_EN 0
`define WF_MP_EN 1
`define WF_WU_EN 2
`define WF_DA_EN 3
`define WF_RXLP_EN 10
`define WF_TXLP_EN 12
`define WF_RFE_EN 14
`define WF_RCLR 0
`define WF_EEE 1
`define WF_PIN_LO 20
`define WF_V4_EN 0
`define WF_V6_EN 1
`define WF_FNS 9
`define WF_FARP 10
`define WF_BYPASS 31
`define WF_LOG_V6 16
`define WF_LOG_V4 15
`define WF_LOG_TXLP 14
`define WF_LOG_RXLP 13
`define WF_LOG_RFE 12
`define WF_LOG_DA 11
`define WF_LOG_MP 10
`define WF_LOG_BC 9
`define WF_LOG_WU 8
`define WF_LOG_CAUSE_LO 8
`define WF_IDX_MSB 4
`define WF_CFG_EN 31
`define WF_CFG_AT_LO 24
`define WF_CFG_OFS_LO 16
`define WF_CFG_CRC_MSB 15
`define WF_AV 31
`define WF_AT 30
`define WF_AHI_MSB 15

`endif

// ==== rtl/wake_filter_pkg.sv ====
// Types shared by the wake filter design.
// Assumes nothing of its surroundings.
package wake_filter_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_ARMED, ST_WAKING} wake_state_t;
  typedef logic [15:0] crc_t;
endpackage : wake_filter_pkg

// ==== verification/rx_frame_source.sv ====
// Behavioural receive datapath that feeds whole frames to the wake filter.
// Assumes the bench calls send_frame; flags are valid with the end byte.
`timescale 1ns/10ps
module rx_frame_source (
  input wire logic clock_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_sof_out,
  output logic rx_eof_out,
  output logic [7:0] rx_flags_out
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h5a;
    rx_sof_out = 1'b0;
    rx_eof_out = 1'b0;
    rx_flags_out = 8'h00;
  end
  task automatic send_frame(input logic [7:0] fr [$], input logic [7:0] flags);
    for (int i = 0; i < fr.size(); i++) begin
      @(posedge clock_in);
      rx_valid_out <= 1'b1;
      rx_data_out <= fr[i];
      rx_sof_out <= (i == 0);
      rx_eof_out <= (i == fr.size() - 1);
      rx_flags_out <= (i == fr.size() - 1) ? flags : ~flags;
    end
    @(posedge clock_in);
    rx_valid_out <= 1'b0;
    rx_sof_out <= 1'b0;
    rx_eof_out <= 1'b0;
    rx_flags_out <= ~flags;
    rx_data_out <= ~fr[fr.size() - 1];
  endtask : send_frame
endmodule : rx_frame_source

// ==== verification/lan_wake_filter_and_source_log_test.sv ====
// Self-checking bench for the wake filter and cause log.
// Assumes the design, its package and register header are compiled first.
`timescale 1ns/10ps
`include "wake_filter_regs.svh"
module lan_wake_filter_and_source_log_test;
  logic clock_in, reset_n_in, cyc, stb, we, ack, wake, disc;
  logic suspend, entering, resume, lite, img_v;
  logic [11:0] adr;
  logic [31:0] dat, rdat, img_cfg, q;
  logic [127:0] img_mask;
  logic [7:0] pins, fl, rxd;
  logic rxv, sof, eof, txlp, rxlp;
  logic [7:0] fr [$];
  int n_fail, checked, n_disc, cycles, idx;
  integer seed;
  logic [7:0] ofs;
  logic [31:0] m;
  logic [9:0] side;

  rx_frame_source u_src (.clock_in(clock_in), .rx_valid_out(rxv), .rx_data_out(rxd),
    .rx_sof_out(sof), .rx_eof_out(eof), .rx_flags_out(fl));
  lan_wake_filter_and_source_log u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
    .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack), .rx_valid_in(rxv),
    .rx_data_in(rxd), .rx_sof_in(sof), .rx_eof_in(eof), .rx_good_in(fl[0]),
    .rx_csum_ok_in(fl[1]), .rx_filter_pass_in(fl[2]), .rx_magic_in(fl[3]),
    .rx_v4_syn_in(fl[4]), .rx_v6_syn_in(fl[5]), .rx_arp_in(fl[6]), .rx_ns_in(fl[7]),
    .tx_lpi_exit_in(txlp), .rx_lpi_exit_in(rxlp), .pin_wake_in(pins),
    .suspend_state_in(suspend), .entering_suspend_in(entering), .resume_done_in(resume),
    .lite_reset_in(lite), .image_valid_in(img_v), .image_cfg_in(img_cfg),
    .image_mask_in(img_mask), .wake_request_out(wake), .frame_discard_out(disc));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #50 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (disc === 1'b1) n_disc <= n_disc + 1;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict;
    end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clock_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // Hold the request until ack is sampled high at a rising edge
    do @(posedge clock_in); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  function automatic logic [15:0] crc_of(input int o, input logic [31:0] mk);
    logic [15:0] c = 16'hffff;
    for (int j = 0; j < 32; j++)
      if (mk[j]) for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[o + j][k]) ? 16'h8005 : 16'h0);
    return c;
  endfunction : crc_of
  task new_frame(input logic bc);
    fr = {};
    for (int i = 0; i < 48; i++) fr.push_back((bc && i < 6) ? 8'hff : 8'($random(seed)));
  endtask : new_frame
  task automatic wake_case(input logic [31:0] ctrl, input logic [31:0] offl,
    input logic [7:0] flags, input logic ent, input logic [31:0] exp);
    wb(1'b1, `WF_CTRL_ADR, ctrl, q);
    wb(1'b1, `WF_OFFL_ADR, offl, q);
    suspend <= 1'b1;
    entering <= ent;
    @(posedge clock_in);
    {pins, rxlp, txlp} <= side;
    @(posedge clock_in);
    {rxlp, txlp} <= 2'b00;
    u_src.send_frame(fr, flags);
    @(negedge clock_in);
    check({31'h0, wake}, {31'h0, exp != 32'h0}, "wake request");
    wb(1'b0, `WF_LOG_ADR, 32'h0, q);
    check(q, exp, "cause log");
    @(posedge clock_in);
    resume <= 1'b1;
    @(posedge clock_in);
    resume <= 1'b0;
    suspend <= 1'b0;
    entering <= 1'b0;
    wb(1'b0, `WF_LOG_ADR, 32'h0, q);
    check(q, exp, "log after resume");
    wb(1'b0, `WF_CTRL_ADR, 32'h0, q);
    check(q, 32'h0, "enables after resume");
    wb(1'b1, `WF_LOG_ADR, 32'hffff_ffff, q);
    pins <= 8'h00;
    $display("case done, log %h", exp);
  endtask : wake_case

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h539e;
    {clock_in, reset_n_in, cyc, stb, we, suspend, entering, resume, lite, img_v} = 10'h0;
    {adr, dat, img_cfg, img_mask, pins, txlp, rxlp, side} = '0;
    {n_fail, checked, n_disc, cycles} = '0;
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    wb(1'b0, `WF_CFG_BASE, 32'h0, q);
    check(q, 32'h0, "filter0 reset");
    wb(1'b0, 12'h7fc, 32'h0, q);
    check(q, 32'h0, "unmapped read");
    img_cfg <= $random(seed) & 32'h7fff_ffff;
    img_mask <= {4{32'($random(seed))}};
    img_v <= 1'b1;
    lite <= 1'b1;
    @(posedge clock_in);
    lite <= 1'b0;
    wb(1'b0, `WF_CFG_BASE, 32'h0, q);
    check(q, img_cfg & `WF_CFG_WMASK, "filter0 image");
    wb(1'b1, `WF_AUX_ADR, 32'h0ff0_0003, q);
    new_frame(1'b0);
    wake_case(32'h2, 32'h0, 8'h4b, 1'b0, 32'h400);
    new_frame(1'b1);
    wake_case(32'h3, 32'h0, 8'h09, 1'b0, 32'h600);
    wake_case(32'h3, 32'h0, 8'h09, 1'b1, 32'h0);
    new_frame(1'b0);
    wake_case(32'h0, 32'h401, 8'h53, 1'b0, 32'h8000);
    wake_case(32'h0, 32'h2, 8'h21, 1'b0, 32'h0);
    wake_case(32'h0, 32'h8000_0002, 8'h21, 1'b0, 32'h1_0000);
    wb(1'b1, `WF_ADDR_BASE, 32'h0, q);
    wb(1'b1, `WF_ADDR_BASE + 12'h004, {fr[2], fr[3], fr[4], fr[5]}, q);
    wb(1'b1, `WF_ADDR_BASE, {16'h8000, fr[0], fr[1]}, q);
    wake_case(32'h4008, 32'h0, 8'h05, 1'b0, 32'h1800);
    // Low-power exits and pin edges; a pin edge after waking began is ignored
    side = 10'h005;
    wake_case(32'h1000, 32'h0, 8'h00, 1'b0, 32'h4000);
    side = 10'h003;
    wake_case(32'h400, 32'h0, 8'h00, 1'b0, 32'h2000);
    side = 10'h004;
    wake_case(32'h0, 32'h0, 8'h00, 1'b0, 32'h10_0000);
    side = 10'h000;
    idx = 1 + ($random(seed) & 30);
    ofs = 8'($random(seed) & 7);
    m = $random(seed) | 32'h1;
    for (int en = 0; en < 2; en++) begin
      wb(1'b1, `WF_MASK_BASE + 12'(idx * 16), m, q);
      wb(1'b1, `WF_CFG_BASE + 12'(idx * 4), {en[0], 7'h01, ofs, crc_of(ofs, m)}, q);
      wake_case(32'h4, 32'h0, 8'h01, 1'b0, en ? (32'h100 | idx) : 32'h0);
    end
    check(n_disc, 1, "discard pulses");
    print_verdict;
  end
endmodule : lan_wake_filter_and_source_log_test
